// >>> rtl/dbfa_pkg.sv
// Purpose: constants for the debug register field-access bank
// Assumes: one debug controller, two harts, 7-bit register bus address
// Notes: offsets shared by design and bench; field positions used by the design only
package dbfa_pkg;
	localparam int NHARTS = 2;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 32;
	localparam int HSEL_W = 4;
	localparam int POKE_W = 8;
	localparam int OWNER_W = 4;
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 7'h10;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 7'h11;
	localparam logic [ADDR_W-1:0] ADDR_SCRATCH = 7'h12;
	localparam int CTRL_HALT_BIT = 0;
	localparam int CTRL_RESUME_BIT = 1;
	localparam int CTRL_STEP_BIT = 2;
	localparam int CTRL_HSEL_LSB = 4;
	localparam int CTRL_POKE_LSB = 8;
	localparam int STAT_HALTED_LSB = 0;
	localparam int STAT_NOTICE_LSB = 8;
	localparam logic [HSEL_W-1:0] HSEL_RESET = 4'h0;
	localparam logic STEP_RESET = 1'b0;
	// preset value of the scratch field, arbitrary but legal
	localparam logic [DATA_W-1:0] SCRATCH_PRESET = 32'h0000_00a5;
	// identity of this controller, value is arbitrary
	localparam logic [OWNER_W-1:0] CONTROLLER_ID = 4'h1;
endpackage

// >>> rtl/dbfa_field_bank.sv
// Purpose: debug register bank with the common field access types and hart run control
// Assumes: requester on the same clock, one request per cycle at most
// Notes: answer comes one cycle after each request
module dbfa_field_bank (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic req_valid_i,
	input wire logic req_write_i,
	input wire logic [dbfa_pkg::ADDR_W-1:0] req_addr_i,
	input wire logic [dbfa_pkg::DATA_W-1:0] req_wdata_i,
	output logic resp_valid_o,
	output logic [dbfa_pkg::DATA_W-1:0] resp_rdata_o,
	input wire logic [dbfa_pkg::NHARTS-1:0] hart_trigger_i,
	input wire logic [dbfa_pkg::NHARTS-1:0] hart_retire_i,
	output logic [dbfa_pkg::NHARTS-1:0] hart_halted_o,
	output logic [dbfa_pkg::NHARTS-1:0] hart_halt_event_o,
	output logic [dbfa_pkg::NHARTS*dbfa_pkg::OWNER_W-1:0] hart_owner_o
);
	function automatic logic [dbfa_pkg::HSEL_W-1:0] legal_hsel(
		input logic [dbfa_pkg::HSEL_W-1:0] v);
		if (v < dbfa_pkg::HSEL_W'(dbfa_pkg::NHARTS)) begin
			legal_hsel = v;
		end else begin
			legal_hsel = dbfa_pkg::HSEL_W'(dbfa_pkg::NHARTS - 1);
		end
	endfunction

	function automatic logic is_write(input logic [dbfa_pkg::ADDR_W-1:0] a,
		input logic v, input logic w, input logic [dbfa_pkg::ADDR_W-1:0] x);
		is_write = v & w & (a == x);
	endfunction

	logic wr_ctrl;
	logic wr_status;
	logic wr_scratch;
	logic notice_clr;
	logic [dbfa_pkg::HSEL_W-1:0] hsel;
	logic step_en;
	logic [dbfa_pkg::DATA_W-1:0] scratch;
	logic [dbfa_pkg::NHARTS-1:0] halted;
	logic [dbfa_pkg::NHARTS-1:0] step_act;
	logic [dbfa_pkg::NHARTS-1:0] notice;
	logic [dbfa_pkg::NHARTS-1:0] enter;
	logic [dbfa_pkg::NHARTS-1:0] resume;
	logic [dbfa_pkg::DATA_W-1:0] next_rdata;

	assign wr_ctrl = is_write(req_addr_i, req_valid_i, req_write_i, dbfa_pkg::ADDR_CTRL);
	assign wr_status = is_write(req_addr_i, req_valid_i, req_write_i, dbfa_pkg::ADDR_STATUS);
	assign wr_scratch = is_write(req_addr_i, req_valid_i, req_write_i, dbfa_pkg::ADDR_SCRATCH);
	// only an all-ones write clears; all zeros and mixed leave the field
	assign notice_clr = wr_status & (&req_wdata_i[dbfa_pkg::STAT_NOTICE_LSB +: dbfa_pkg::NHARTS]);

	// control fields
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			hsel <= dbfa_pkg::HSEL_RESET;
			step_en <= dbfa_pkg::STEP_RESET;
		end else if (wr_ctrl) begin
			hsel <= legal_hsel(req_wdata_i[dbfa_pkg::CTRL_HSEL_LSB +: dbfa_pkg::HSEL_W]);
			step_en <= req_wdata_i[dbfa_pkg::CTRL_STEP_BIT];
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			scratch <= dbfa_pkg::SCRATCH_PRESET;
		end else if (wr_scratch) begin
			scratch <= req_wdata_i;
		end
	end

	// per-hart run control
	generate
		for (genvar h = 0; h < dbfa_pkg::NHARTS; h++) begin : g_hart
			logic sel;
			logic halt_req;
			assign sel = (hsel == dbfa_pkg::HSEL_W'(h));
			// write-one-only: a zero in these bits does nothing
			assign halt_req = wr_ctrl & sel & req_wdata_i[dbfa_pkg::CTRL_HALT_BIT];
			assign resume[h] = wr_ctrl & sel & halted[h]
				& req_wdata_i[dbfa_pkg::CTRL_RESUME_BIT];
			assign enter[h] = ~halted[h]
				& (halt_req | hart_trigger_i[h] | (step_act[h] & hart_retire_i[h]));
			assign hart_owner_o[h*dbfa_pkg::OWNER_W +: dbfa_pkg::OWNER_W] =
				dbfa_pkg::CONTROLLER_ID;

			always_ff @(posedge core_clk_i) begin
				if (!rstn_i) begin
					halted[h] <= 1'b0;
				end else if (enter[h]) begin
					halted[h] <= 1'b1;
				end else if (resume[h]) begin
					halted[h] <= 1'b0;
				end
			end

			always_ff @(posedge core_clk_i) begin
				if (!rstn_i) begin
					step_act[h] <= 1'b0;
				end else if (resume[h]) begin
					step_act[h] <= step_en;
				end else if (enter[h]) begin
					step_act[h] <= 1'b0;
				end
			end

			// set wins over the clear
			always_ff @(posedge core_clk_i) begin
				if (!rstn_i) begin
					notice[h] <= 1'b0;
				end else if (enter[h]) begin
					notice[h] <= 1'b1;
				end else if (notice_clr) begin
					notice[h] <= 1'b0;
				end
			end

			always_ff @(posedge core_clk_i) begin
				if (!rstn_i) begin
					hart_halt_event_o[h] <= 1'b0;
				end else begin
					hart_halt_event_o[h] <= enter[h];
				end
			end
		end
	endgenerate

	assign hart_halted_o = halted;

	// read data: reserved, write-only and read-zero fields stay zero
	always_comb begin
		next_rdata = '0;
		if (req_valid_i && !req_write_i) begin
			unique case (req_addr_i)
				dbfa_pkg::ADDR_CTRL: begin
					next_rdata[dbfa_pkg::CTRL_STEP_BIT] = step_en;
					next_rdata[dbfa_pkg::CTRL_HSEL_LSB +: dbfa_pkg::HSEL_W] = hsel;
				end
				dbfa_pkg::ADDR_STATUS: begin
					next_rdata[dbfa_pkg::STAT_HALTED_LSB +: dbfa_pkg::NHARTS] = halted;
					next_rdata[dbfa_pkg::STAT_NOTICE_LSB +: dbfa_pkg::NHARTS] = notice;
				end
				dbfa_pkg::ADDR_SCRATCH: begin
					next_rdata = scratch;
				end
				default: begin
					next_rdata = '0;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			resp_valid_o <= 1'b0;
			resp_rdata_o <= '0;
		end else begin
			resp_valid_o <= req_valid_i;
			resp_rdata_o <= next_rdata;
		end
	end

	sequence s_ctrl_read;
		req_valid_i && !req_write_i && req_addr_i == dbfa_pkg::ADDR_CTRL;
	endsequence

	sequence s_step_resume;
		wr_ctrl && hsel == 4'h0 && halted[0] && step_en && req_wdata_i[1];
	endsequence

	property p_reserved_zero;
		@(posedge core_clk_i) disable iff (!rstn_i)
		s_ctrl_read |=> resp_valid_o && resp_rdata_o[31:16] == 16'h0000 && resp_rdata_o[3] == 1'b0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved ctrl bits not zero");

	property p_read_zero;
		@(posedge core_clk_i) disable iff (!rstn_i)
		s_ctrl_read |=> resp_rdata_o[15:8] == 8'h00;
	endproperty
	a_read_zero: assert property (p_read_zero) else $error("poke field read nonzero");

	property p_one_only;
		@(posedge core_clk_i) disable iff (!rstn_i)
		s_ctrl_read |=> resp_rdata_o[1:0] == 2'b00;
	endproperty
	a_one_only: assert property (p_one_only) else $error("write-one-only bits read nonzero");

	property p_zero_no_halt;
		@(posedge core_clk_i) disable iff (!rstn_i)
		wr_ctrl && hsel == 4'h0 && !req_wdata_i[0] && !halted[0] && !hart_trigger_i[0]
			&& !step_act[0] |=> !halted[0];
	endproperty
	a_zero_no_halt: assert property (p_zero_no_halt) else $error("zero write halted hart");

	property p_clear_ones;
		@(posedge core_clk_i) disable iff (!rstn_i)
		wr_status && req_wdata_i[9:8] == 2'b11 && enter == 2'b00 |=> notice == 2'b00;
	endproperty
	a_clear_ones: assert property (p_clear_ones) else $error("all-ones write did not clear");

	property p_clear_zeros;
		@(posedge core_clk_i) disable iff (!rstn_i)
		wr_status && req_wdata_i[9:8] == 2'b00 && enter == 2'b00 |=> notice == $past(notice);
	endproperty
	a_clear_zeros: assert property (p_clear_zeros) else $error("all-zeros write changed field");

	property p_legal_sel;
		@(posedge core_clk_i) disable iff (!rstn_i)
		wr_ctrl && req_wdata_i[7:4] > 4'h1 |=> hsel == 4'h1;
	endproperty
	a_legal_sel: assert property (p_legal_sel) else $error("illegal hart select kept");

	property p_preset;
		@(posedge core_clk_i)
		!rstn_i |=> scratch == 32'h0000_00a5 && hsel == 4'h0 && !step_en;
	endproperty
	a_preset: assert property (p_preset) else $error("reset value wrong");

	property p_owner;
		@(posedge core_clk_i) disable iff (!rstn_i)
		hart_owner_o[3:0] == 4'h1 && hart_owner_o[7:4] == 4'h1;
	endproperty
	a_owner: assert property (p_owner) else $error("hart owner not this controller");

	property p_trigger_halt;
		@(posedge core_clk_i) disable iff (!rstn_i)
		!halted[1] && hart_trigger_i[1] |=> hart_halted_o[1] && hart_halt_event_o[1] && notice[1];
	endproperty
	a_trigger_halt: assert property (p_trigger_halt) else $error("trigger did not halt hart");

	property p_single_step;
		@(posedge core_clk_i) disable iff (!rstn_i)
		s_step_resume ##1 (!halted[0] && hart_retire_i[0]) |=> halted[0] && hart_halt_event_o[0];
	endproperty
	a_single_step: assert property (p_single_step) else $error("step did not halt after one");
endmodule

// >>> tb/dbfa_manager.sv
// Purpose: transport manager model driving the debug register bus
// Assumes: one request at a time, answer exactly one cycle later
// Notes: address and data lines carry inverted values while idle
module dbfa_manager (
	input wire logic core_clk_i,
	output logic req_valid_o,
	output logic req_write_o,
	output logic [dbfa_pkg::ADDR_W-1:0] req_addr_o,
	output logic [dbfa_pkg::DATA_W-1:0] req_wdata_o,
	input wire logic resp_valid_i,
	input wire logic [dbfa_pkg::DATA_W-1:0] resp_rdata_i
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		req_valid_o = 1'b0;
		req_write_o = 1'b0;
		req_addr_o = '0;
		req_wdata_o = '0;
	end
	// one access; ok is low when no answer stands one cycle later
	task automatic access(input logic wr, input logic [dbfa_pkg::ADDR_W-1:0] a,
			input logic [dbfa_pkg::DATA_W-1:0] d, output logic [dbfa_pkg::DATA_W-1:0] q,
			output bit ok);
		@(posedge core_clk_i);
		#1;
		req_valid_o = 1'b1;
		req_write_o = wr;
		req_addr_o = a;
		req_wdata_o = d;
		@(posedge core_clk_i);
		#1;
		req_valid_o = 1'b0;
		req_addr_o = ~a;
		req_wdata_o = ~d;
		q = resp_rdata_i;
		ok = (resp_valid_i === 1'b1);
	endtask
endmodule

// >>> tb/dbfa_field_bank_test.sv
// Purpose: self-checking bench for the debug field bank
// Assumes: manager model issues all register accesses
// Notes: scratch and poke values are random from a fixed seed
module dbfa_field_bank_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk_i;
	logic rstn_i;
	logic rv;
	logic rw;
	logic pv;
	logic [dbfa_pkg::ADDR_W-1:0] ra;
	logic [31:0] wd, pd, q, r;
	logic [1:0] trig, ret, halted, hev;
	logic [7:0] owner;
	bit ok;
	int errors;
	int comparisons;
	dbfa_manager mgr (.core_clk_i(core_clk_i), .req_valid_o(rv), .req_write_o(rw),
		.req_addr_o(ra), .req_wdata_o(wd), .resp_valid_i(pv), .resp_rdata_i(pd));
	dbfa_field_bank dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .req_valid_i(rv),
		.req_write_i(rw), .req_addr_i(ra), .req_wdata_i(wd), .resp_valid_o(pv),
		.resp_rdata_o(pd), .hart_trigger_i(trig), .hart_retire_i(ret),
		.hart_halted_o(halted), .hart_halt_event_o(hev), .hart_owner_o(owner));
	initial begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic acc(input logic wr, input logic [6:0] a, input logic [31:0] d);
		mgr.access(wr, a, d, q, ok);
		if (!ok) begin
			errors++;
			summarize();
		end
	endtask
	function automatic logic [31:0] ctrl(bit h, bit rs, bit st, logic [3:0] s, logic [7:0] p);
		ctrl = {16'h0000, p, s, 1'b0, st, rs, h};
	endfunction
	function automatic logic [31:0] ctrl_exp(bit st, logic [3:0] s);
		ctrl_exp = ctrl(1'b0, 1'b0, st, (s > 4'h1) ? 4'h1 : s, 8'h00);
	endfunction
	// one-cycle pulse on a hart input, then the halt answer and event length
	task automatic pulse(input bit tr, input int h, input logic eh, input logic ee);
		@(posedge core_clk_i);
		#1;
		if (tr)
			trig[h] = 1'b1;
		else
			ret[h] = 1'b1;
		@(posedge core_clk_i);
		#1;
		trig = 2'b00;
		ret = 2'b00;
		check("halted", {31'h0, halted[h]}, {31'h0, eh});
		check("halt event", {31'h0, hev[h]}, {31'h0, ee});
		@(posedge core_clk_i);
		#1;
		check("event end", {31'h0, hev[h]}, 32'h0000_0000);
	endtask
	initial begin
		rstn_i = 1'b0;
		trig = 2'b00;
		ret = 2'b00;
		errors = 0;
		comparisons = 0;
		void'($urandom(80858));
		repeat (2) @(posedge core_clk_i);
		#1;
		rstn_i = 1'b1;
		check("owner", {24'h0, owner}, {24'h0, {2{dbfa_pkg::CONTROLLER_ID}}});
		acc(1'b0, dbfa_pkg::ADDR_CTRL, 0);
		check("ctrl reset", q, ctrl_exp(dbfa_pkg::STEP_RESET, dbfa_pkg::HSEL_RESET));
		acc(1'b0, dbfa_pkg::ADDR_SCRATCH, 0);
		check("scratch reset", q, dbfa_pkg::SCRATCH_PRESET);
		for (int i = 0; i < 4; i++) begin
			r = $urandom;
			acc(1'b1, dbfa_pkg::ADDR_SCRATCH, r);
			acc(1'b0, dbfa_pkg::ADDR_SCRATCH, 0);
			check("scratch", q, r);
		end
		for (int i = 0; i < 16; i++) begin
			acc(1'b1, dbfa_pkg::ADDR_CTRL, ctrl(0, 0, i[0], i[3:0], 8'($urandom)));
			acc(1'b0, dbfa_pkg::ADDR_CTRL, 0);
			check("ctrl", q, ctrl_exp(i[0], i[3:0]));
		end
		check("no halt on zero", {30'h0, halted}, 32'h0000_0000);
		acc(1'b1, 7'h13, 32'hffff_ffff);
		acc(1'b1, dbfa_pkg::ADDR_STATUS, 32'h0000_00ff);
		acc(1'b0, 7'h13, 0);
		check("unmapped", q, 32'h0000_0000);
		acc(1'b0, dbfa_pkg::ADDR_STATUS, 0);
		check("status", q, 32'h0000_0000);
		pulse(1'b1, 1, 1'b1, 1'b1);
		pulse(1'b1, 1, 1'b1, 1'b0);
		acc(1'b1, dbfa_pkg::ADDR_STATUS, 0);
		acc(1'b0, dbfa_pkg::ADDR_STATUS, 0);
		check("notice kept", q, 32'h0000_0202);
		acc(1'b1, dbfa_pkg::ADDR_STATUS, 32'h0000_0300);
		acc(1'b0, dbfa_pkg::ADDR_STATUS, 0);
		check("notice cleared", q, 32'h0000_0002);
		acc(1'b1, dbfa_pkg::ADDR_CTRL, ctrl(0, 0, 0, 4'h0, 8'h00));
		acc(1'b1, dbfa_pkg::ADDR_CTRL, ctrl(1, 0, 0, 4'h0, 8'h00));
		acc(1'b0, dbfa_pkg::ADDR_CTRL, 0);
		check("halt reads zero", q, ctrl_exp(0, 4'h0));
		check("halted by write", {30'h0, halted}, 32'h0000_0003);
		acc(1'b1, dbfa_pkg::ADDR_CTRL, ctrl(0, 0, 1, 4'h0, 8'h00));
		acc(1'b1, dbfa_pkg::ADDR_CTRL, ctrl(0, 1, 1, 4'h0, 8'h00));
		// step arms from the step bit held before the resume write
		check("resumed", {30'h0, halted}, 32'h0000_0002);
		ret[0] = 1'b1;
		@(posedge core_clk_i);
		#1;
		ret = 2'b00;
		check("stepped", {30'h0, halted}, 32'h0000_0003);
		check("step event", {31'h0, hev[0]}, 32'h0000_0001);
		@(posedge core_clk_i);
		#1;
		check("step event end", {31'h0, hev[0]}, 32'h0000_0000);
		acc(1'b1, dbfa_pkg::ADDR_CTRL, ctrl(0, 0, 0, 4'h0, 8'h00));
		acc(1'b1, dbfa_pkg::ADDR_CTRL, ctrl(0, 1, 0, 4'h0, 8'h00));
		pulse(1'b0, 0, 1'b0, 1'b0);
		// second reset after the fields were changed
		rstn_i = 1'b0;
		@(posedge core_clk_i);
		#1;
		rstn_i = 1'b1;
		check("halted after reset", {30'h0, halted}, 32'h0000_0000);
		acc(1'b0, dbfa_pkg::ADDR_SCRATCH, 0);
		check("scratch preset again", q, dbfa_pkg::SCRATCH_PRESET);
		acc(1'b0, dbfa_pkg::ADDR_CTRL, 0);
		check("ctrl after reset", q, ctrl_exp(dbfa_pkg::STEP_RESET, dbfa_pkg::HSEL_RESET));
		summarize();
	end
endmodule
